// [hw/spc_pkg.sv]
//----------------------------------------------------------------------
// Status pin configuration and start-up status: shared constants
//----------------------------------------------------------------------
// Purpose: Offsets, field positions, reset values and source codes.
// Assumes: Avalon-MM word addressing, 32-bit data, 20 MHz clock.
// Notes:   Used by every file except the source bundle and the pad.
//
// Behaviour
// [R1] Open-drain, active high: drive low for 0, release for 1.
// [R2] Open-drain, active low: drive low for 1, release for 0.
// [R3] Tristate bit releases the data-out pin; resets to zero.
// [R4] Pull-down enable bit turns on pull-down; resets off.
// [R5] Pull-up enable bit turns on pull-up; resets on.
// [R6] Polarity bit passes status unchanged at 0, inverted at 1.
// [R7] Source select applies only outside four-wire SPI mode.
// [R8] Source codes 0x0 lock, 0x4 crystal loss, 0x9 masked interrupt.
// [R9] Codes 0xA ready, 0xD low, 0xE high; others reserved.
// [R10] Six pin levels captured at start-up, fixed bit order.
// [R11] Bit 7 of start-up status reads the die bond option.
// [R12] Status pin mirror bit valid for select 0x0..0x4, else 0.
// [R13] Output-gate mirror bit follows pin when function select 0.
// [R14] 32-bit scratch word, reset zero, no hardware effect.
// [R15] Scratch word can be reloaded from stored configuration.
// [R16] Status pin select: 0x1D low, 0x1E high, plus shared codes.
// [R17] Reserved and read-only bits read zero, ignore writes.
//----------------------------------------------------------------------
package spc_pkg;
    // Register word indices
    localparam logic [2:0] REG_DOUT_CFG = 3'h0;
    localparam logic [2:0] REG_BOOT_STS = 3'h1;
    localparam logic [2:0] REG_LIVE_STS = 3'h2;
    localparam logic [2:0] REG_SCRATCH = 3'h3;

    // Data-out configuration fields
    localparam int DOUT_OD_BIT = 12;
    localparam int DOUT_HIZ_BIT = 11;
    localparam int DOUT_PD_BIT = 10;
    localparam int DOUT_PU_BIT = 9;
    localparam int DOUT_POL_BIT = 8;
    localparam int DOUT_SEL_LSB = 0;
    localparam int DOUT_SEL_W = 4;
    localparam logic [15:0] DOUT_CFG_WMASK = 16'h1f0f;
    localparam logic [15:0] DOUT_CFG_RST = 16'h0200;

    // Start-up status fields
    localparam int BOOT_BOND_BIT = 7;
    localparam int BOOT_PINS_W = 6;

    // Live status fields
    localparam int LIVE_STATUS_BIT = 1;
    localparam int LIVE_GATE_BIT = 0;

    localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;

    // Status source codes (low nibble shared by both pins)
    localparam logic [4:0] SRC_LOCK = 5'h00;
    localparam logic [4:0] SRC_XTAL_LOSS = 5'h04;
    localparam logic [4:0] SRC_INT = 5'h09;
    localparam logic [4:0] SRC_READY = 5'h0a;
    localparam logic [4:0] DOUT_SRC_LOW = 5'h0d;
    localparam logic [4:0] DOUT_SRC_HIGH = 5'h0e;
    localparam logic [4:0] STAT_SRC_LOW = 5'h1d;
    localparam logic [4:0] STAT_SRC_HIGH = 5'h1e;
    localparam logic [4:0] STAT_SRC_NOPOL = 5'h1f;
    localparam logic [4:0] STAT_MIRROR_MAX = 5'h04;

    // Avalon response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECODE_ERR = 2'h3;
endpackage

// [hw/spc_src_if.sv]
//----------------------------------------------------------------------
// Status source bundle
//----------------------------------------------------------------------
// Purpose: Carries the device status levels to the source selectors.
// Assumes: All levels synchronous to clk.
// Notes:   One driver (top), many readers (selectors).
`timescale 1ns/10ps
interface spc_src_if;
    logic pll_lock;
    logic xtal_loss;
    logic int_sts;
    logic int_en;
    logic ready;

    modport drv (output pll_lock, xtal_loss, int_sts, int_en, ready);
    modport sel (input pll_lock, xtal_loss, int_sts, int_en, ready);
endinterface

// [hw/spc_src_mux.sv]
//----------------------------------------------------------------------
// Status source selector
//----------------------------------------------------------------------
// Purpose: Picks one status level by code, for either pin.
// Assumes: Reserved codes give a low level.
// Notes:   Width and constant-level codes differ per pin.
`timescale 1ns/10ps
module spc_src_mux
    import spc_pkg::*;
#(
    parameter int SEL_W = 4,
    parameter logic [4:0] LOW_CODE = DOUT_SRC_LOW,
    parameter logic [4:0] HIGH_CODE = DOUT_SRC_HIGH
)
(
    // Sources
    spc_src_if.sel src,
    // Selection
    input wire logic [SEL_W-1:0] sel,
    output logic value
);
    logic [4:0] code;

    // Decode the source code
    always_comb
    begin
        code = 5'(sel);
        value = 1'b0;
        if (code == SRC_LOCK)
            value = src.pll_lock; // R8 R16
        else if (code == SRC_XTAL_LOSS)
            value = src.xtal_loss; // R8 R16
        else if (code == SRC_INT)
            value = src.int_sts & src.int_en; // R8 R16
        else if (code == SRC_READY)
            value = src.ready; // R9 R16
        else if (code == LOW_CODE)
            value = 1'b0; // R9 R16
        else if (code == HIGH_CODE)
            value = 1'b1; // R9 R16
    end
endmodule // spc_src_mux

// [hw/spc_dout_pad.sv]
//----------------------------------------------------------------------
// Data-out pad control
//----------------------------------------------------------------------
// Purpose: Turns status value and pad settings into drive and enable.
// Assumes: Pad resolves open-drain release to pull or external level.
// Notes:   Four-wire SPI owns the pin unless the tristate bit is set.
`timescale 1ns/10ps
module spc_dout_pad
(
    // Status value and pad settings
    input wire logic status_val,
    input wire logic pol,
    input wire logic open_drain,
    input wire logic hiz,
    // Serial port side
    input wire logic spi_4wire_mode,
    input wire logic spi_read_data,
    input wire logic spi_read_oe,
    // Pad drive
    output logic pin_o,
    output logic pin_oe
);
    logic level;

    // Polarity, mode and drive style
    always_comb
    begin
        level = status_val ^ pol; // R6
        pin_o = level;
        pin_oe = 1'b1;
        if (hiz)
        begin
            pin_o = 1'b0;
            pin_oe = 1'b0; // R3
        end
        else if (spi_4wire_mode)
        begin
            pin_o = spi_read_data; // R7
            pin_oe = spi_read_oe; // R7
        end
        else if (open_drain)
        begin
            pin_o = 1'b0;
            pin_oe = ~level; // R1 R2
        end
    end
endmodule // spc_dout_pad

// [hw/spc_top.sv]
//----------------------------------------------------------------------
// Status pin configuration and start-up status
//----------------------------------------------------------------------
// Purpose: Data-out pin as status output, boot capture, live status,
//          scratch word, all behind an Avalon-MM slave.
// Assumes: All inputs synchronous to clk; word addressed bus.
// Notes:   Every access answers one cycle after the request rises.
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
module spc_top
    import spc_pkg::*;
#(
    parameter int ADDR_W = 3
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic [1:0] avs_response,
    output logic avs_waitrequest,
    // Device status sources
    input wire logic pll_lock,
    input wire logic xtal_loss_flag,
    input wire logic device_int_sts,
    input wire logic device_int_en,
    input wire logic startup_done,
    // Status pin settings held elsewhere
    input wire logic [4:0] status_pin_sel,
    input wire logic status_pin_pol,
    // Output-gate pin
    input wire logic output_gate_pin,
    input wire logic output_gate_fn_sel,
    // Serial port mode and read data
    input wire logic spi_4wire_mode,
    input wire logic spi_read_data,
    input wire logic spi_read_oe,
    // Pin levels sampled at boot
    input wire logic status_pin_in,
    input wire logic serial_data_in_pin,
    input wire logic clock_pin_in,
    input wire logic dout_pin_in,
    input wire logic chip_select_n_pin,
    input wire logic die_bond_option,
    // Stored configuration load
    input wire logic otp_load,
    input wire logic [31:0] otp_scratch_word,
    output logic [31:0] scratch_word,
    // Data-out pad
    output logic dout_pin_o,
    output logic dout_pin_oe,
    output logic dout_pullup_en,
    output logic dout_pulldown_en
);
    //------------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------------
    spc_src_if src ();

    logic req;
    logic acc;
    logic mapped;
    logic [31:0] bmask;
    logic waitreq_q, waitreq_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] resp_q, resp_d;

    logic [15:0] dout_cfg_q, dout_cfg_d;
    logic [31:0] scratch_q, scratch_d;
    logic [7:0] boot_sts_q, boot_sts_d;
    logic boot_taken_q, boot_taken_d;
    logic [7:0] live_sts_q, live_sts_d;

    logic dout_status;
    logic stat_raw;
    logic stat_level;
    logic pad_o;
    logic pad_oe;
    logic dout_o_q, dout_oe_q;
    logic pu_q, pd_q;

    //------------------------------------------------------------------
    // Status sources and selectors
    //------------------------------------------------------------------
    // Bundle the status levels
    assign src.pll_lock = pll_lock;
    assign src.xtal_loss = xtal_loss_flag;
    assign src.int_sts = device_int_sts;
    assign src.int_en = device_int_en;
    assign src.ready = startup_done;

    // Data-out pin source
    spc_src_mux #(
        .SEL_W(DOUT_SEL_W),
        .LOW_CODE(DOUT_SRC_LOW),
        .HIGH_CODE(DOUT_SRC_HIGH)
    ) u_dout_mux (
        .src(src),
        .sel(dout_cfg_q[DOUT_SEL_LSB +: DOUT_SEL_W]),
        .value(dout_status)
    );

    // Status pin source, for the mirror bit
    spc_src_mux #(
        .SEL_W(5),
        .LOW_CODE(STAT_SRC_LOW),
        .HIGH_CODE(STAT_SRC_HIGH)
    ) u_stat_mux (
        .src(src),
        .sel(status_pin_sel),
        .value(stat_raw)
    );

    // Polarity ignored on the no-polarity code
    assign stat_level = (status_pin_sel == STAT_SRC_NOPOL) ?
                        stat_raw : (stat_raw ^ status_pin_pol);

    //------------------------------------------------------------------
    // Data-out pad
    //------------------------------------------------------------------
    spc_dout_pad u_pad (
        .status_val(dout_status),
        .pol(dout_cfg_q[DOUT_POL_BIT]),
        .open_drain(dout_cfg_q[DOUT_OD_BIT]),
        .hiz(dout_cfg_q[DOUT_HIZ_BIT]),
        .spi_4wire_mode(spi_4wire_mode),
        .spi_read_data(spi_read_data),
        .spi_read_oe(spi_read_oe),
        .pin_o(pad_o),
        .pin_oe(pad_oe)
    );

    // Register pad drive and pulls
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            dout_o_q <= 1'b0;
            dout_oe_q <= 1'b0;
            pu_q <= DOUT_CFG_RST[DOUT_PU_BIT];
            pd_q <= DOUT_CFG_RST[DOUT_PD_BIT];
        end
        else
        begin
            dout_o_q <= pad_o; // R1 R2 R3
            dout_oe_q <= pad_oe; // R1 R2 R3
            pu_q <= dout_cfg_q[DOUT_PU_BIT]; // R5
            pd_q <= dout_cfg_q[DOUT_PD_BIT]; // R4
        end
    end

    assign dout_pin_o = dout_o_q;
    assign dout_pin_oe = dout_oe_q;
    assign dout_pullup_en = pu_q;
    assign dout_pulldown_en = pd_q;

    //------------------------------------------------------------------
    // Bus handshake
    //------------------------------------------------------------------
    // Access completes while waitrequest is low
    assign req = avs_read | avs_write;
    assign acc = req & ~waitreq_q;
    assign mapped = (avs_address <= ADDR_W'(REG_SCRATCH));

    // Byte enables to bit mask
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            bmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end

    // Waitrequest low for one cycle per request
    always_comb
    begin
        waitreq_d = ~(req & waitreq_q);
    end

    // Read data and response captured one cycle ahead
    always_comb
    begin
        rdata_d = rdata_q;
        resp_d = resp_q;
        if (req & waitreq_q)
        begin
            resp_d = mapped ? RESP_OKAY : RESP_DECODE_ERR;
            rdata_d = 32'h0000_0000; // R17
            if (avs_read)
            begin
                unique case (avs_address)
                    ADDR_W'(REG_DOUT_CFG):
                        rdata_d = {16'h0000, dout_cfg_q};
                    ADDR_W'(REG_BOOT_STS):
                        rdata_d = {24'h00_0000, boot_sts_q};
                    ADDR_W'(REG_LIVE_STS):
                        rdata_d = {24'h00_0000, live_sts_q};
                    ADDR_W'(REG_SCRATCH):
                        rdata_d = scratch_q;
                    default:
                        rdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            waitreq_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            resp_q <= RESP_OKAY;
        end
        else
        begin
            waitreq_q <= waitreq_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
        end
    end

    assign avs_waitrequest = waitreq_q;
    assign avs_readdata = rdata_q;
    assign avs_response = resp_q;

    //------------------------------------------------------------------
    // Writable registers
    //------------------------------------------------------------------
    // Configuration and scratch next values
    always_comb
    begin
        dout_cfg_d = dout_cfg_q;
        scratch_d = scratch_q;
        if (acc & avs_write & (avs_address == ADDR_W'(REG_DOUT_CFG)))
        begin
            dout_cfg_d = (dout_cfg_q & ~(bmask[15:0] & DOUT_CFG_WMASK)) |
                (avs_writedata[15:0] & bmask[15:0] & DOUT_CFG_WMASK); // R17
        end
        if (otp_load)
            scratch_d = otp_scratch_word; // R15
        else if (acc & avs_write & (avs_address == ADDR_W'(REG_SCRATCH)))
            scratch_d = (scratch_q & ~bmask) | (avs_writedata & bmask); // R14
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            dout_cfg_q <= DOUT_CFG_RST; // R3 R4 R5 R6
            scratch_q <= SCRATCH_RST; // R14
        end
        else
        begin
            dout_cfg_q <= dout_cfg_d;
            scratch_q <= scratch_d;
        end
    end

    assign scratch_word = scratch_q;

    //------------------------------------------------------------------
    // Start-up capture
    //------------------------------------------------------------------
    // Latch pins once, first cycle after reset release
    always_comb
    begin
        boot_sts_d = boot_sts_q;
        boot_taken_d = 1'b1;
        if (~boot_taken_q)
        begin
            boot_sts_d = {die_bond_option, 1'b0, chip_select_n_pin,
                          output_gate_pin, dout_pin_in, clock_pin_in,
                          serial_data_in_pin, status_pin_in}; // R10 R11
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            boot_sts_q <= 8'h00;
            boot_taken_q <= 1'b0;
        end
        else
        begin
            boot_sts_q <= boot_sts_d;
            boot_taken_q <= boot_taken_d;
        end
    end

    //------------------------------------------------------------------
    // Live status
    //------------------------------------------------------------------
    // Mirror status pin and output-gate pin
    always_comb
    begin
        live_sts_d = 8'h00; // R17
        if (status_pin_sel <= STAT_MIRROR_MAX)
            live_sts_d[LIVE_STATUS_BIT] = stat_level; // R12
        live_sts_d[LIVE_GATE_BIT] = output_gate_pin &
                                    ~output_gate_fn_sel; // R13
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            live_sts_q <= 8'h00;
        else
            live_sts_q <= live_sts_d;
    end
endmodule // spc_top

// [tb/spc_top_props.sv]
//----------------------------------------------------------------------
// Status pin block port checker
//----------------------------------------------------------------------
// Purpose: Assertions on bus, pad, pulls and scratch.
// Assumes: Writes land where waitrequest is seen low.
// Notes:   Shadows of config and scratch follow the bus.
`timescale 1ns/10ps
module spc_top_props
    import spc_pkg::*;
#(
    parameter int ADDR_W = 3
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic [1:0] avs_response,
    input wire logic avs_waitrequest,
    // Status sources and serial port
    input wire logic pll_lock,
    input wire logic xtal_loss_flag,
    input wire logic device_int_sts,
    input wire logic device_int_en,
    input wire logic startup_done,
    input wire logic spi_4wire_mode,
    input wire logic spi_read_data,
    input wire logic spi_read_oe,
    // Scratch load and pad
    input wire logic otp_load,
    input wire logic [31:0] otp_scratch_word,
    input wire logic [31:0] scratch_word,
    input wire logic dout_pin_o,
    input wire logic dout_pin_oe,
    input wire logic dout_pullup_en,
    input wire logic dout_pulldown_en
);
    //------------------------------------------------------------------
    // Shadow state
    //------------------------------------------------------------------
    logic [31:0] m, scr_q, scr_d;
    logic [15:0] cm, cfg_q, cfg_d;
    logic live_q, src, wr_ok;

    // Byte lane mask and accepted write
    assign m = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign cm = m[15:0] & DOUT_CFG_WMASK;
    assign wr_ok = avs_write && !avs_waitrequest;

    // Next shadow values
    always_comb
    begin
        cfg_d = cfg_q;
        scr_d = scr_q;
        if (wr_ok && avs_address == ADDR_W'(REG_DOUT_CFG))
            cfg_d = (cfg_q & ~cm) | (avs_writedata[15:0] & cm);
        if (otp_load)
            scr_d = otp_scratch_word;
        else if (wr_ok && avs_address == ADDR_W'(REG_SCRATCH))
            scr_d = (scr_q & ~m) | (avs_writedata & m);
    end

    // Shadows; live_q marks a cycle out of reset
    always_ff @(posedge clk)
    begin
        live_q <= !srst;
        cfg_q <= srst ? DOUT_CFG_RST : cfg_d;
        scr_q <= srst ? SCRATCH_RST : scr_d;
    end

    // Expected status per code
    always_comb
    begin
        case (cfg_q[3:0])
            4'h0: src = pll_lock;
            4'h4: src = xtal_loss_flag;
            4'h9: src = device_int_sts & device_int_en;
            4'ha: src = startup_done;
            4'he: src = 1'b1;
            default: src = 1'b0;
        endcase
    end

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_ANSWER: assert property ($rose(avs_read || avs_write)
        |=> !avs_waitrequest) else $error("late bus answer");
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    AST_DECODE: assert property (!avs_waitrequest && avs_read
        && avs_address > 3 |-> avs_response == RESP_DECODE_ERR
        && avs_readdata == 32'h0) else $error("bad unmapped read");
    AST_CFG_RD: assert property (!avs_waitrequest && avs_read
        && avs_address == 0 |-> avs_readdata == {16'h0, cfg_q})
        else $error("config readback wrong");
    AST_SCRATCH: assert property (scratch_word == scr_q)
        else $error("scratch word wrong");
    AST_HIZ: assert property (live_q && $past(cfg_q[DOUT_HIZ_BIT])
        |-> !dout_pin_oe) else $error("pin driven in tristate");
    AST_SPI: assert property (live_q
        && $past(spi_4wire_mode && !cfg_q[DOUT_HIZ_BIT])
        |-> dout_pin_o == $past(spi_read_data)
        && dout_pin_oe == $past(spi_read_oe)) else $error("spi data lost");
    AST_PUSH: assert property (live_q
        && $past(!spi_4wire_mode && cfg_q[12:11] == 2'b00)
        |-> dout_pin_oe && dout_pin_o == $past(src ^ cfg_q[8]))
        else $error("push-pull value wrong");
    AST_OD: assert property (live_q
        && $past(!spi_4wire_mode && cfg_q[12:11] == 2'b10)
        |-> !dout_pin_o && dout_pin_oe == $past(!(src ^ cfg_q[8])))
        else $error("open-drain drive wrong");
    AST_PULL: assert property ($stable(cfg_q)
        |-> dout_pullup_en == cfg_q[9] && dout_pulldown_en == cfg_q[10])
        else $error("pull enable wrong");
endmodule // spc_top_props

bind spc_top spc_top_props #(.ADDR_W(ADDR_W)) props_u (.*);

// [tb/spc_top_tb_top.sv]
//----------------------------------------------------------------------
// Status pin block testbench
//----------------------------------------------------------------------
// Purpose: Directed bus and pad scenarios.
// Assumes: Pad and live status lag one edge.
// Notes:   Boot pins hold until capture.
`timescale 1ns/10ps
module spc_top_tb_top
    import spc_pkg::*;
;
    logic clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [2:0] avs_address = 3'h0;
    logic [31:0] avs_writedata = 32'h0, otp_scratch_word = 32'h0;
    logic [31:0] avs_readdata, scratch_word, rd;
    logic [3:0] avs_byteenable = 4'hf;
    logic [1:0] avs_response, rs;
    logic avs_waitrequest, dout_pin_o, dout_pin_oe;
    logic dout_pullup_en, dout_pulldown_en, otp_load = 1'b0;
    logic pll_lock = 1'b0, xtal_loss_flag = 1'b0, device_int_sts = 1'b0;
    logic device_int_en = 1'b0, startup_done = 1'b0, status_pin_pol = 1'b0;
    logic [4:0] status_pin_sel = 5'h0;
    logic output_gate_pin = 1'b0, output_gate_fn_sel = 1'b0;
    logic spi_4wire_mode = 1'b0, spi_read_data = 1'b0, spi_read_oe = 1'b0;
    logic status_pin_in = 1'b1, serial_data_in_pin = 1'b0;
    logic clock_pin_in = 1'b1, dout_pin_in = 1'b1;
    logic chip_select_n_pin = 1'b1, die_bond_option = 1'b1;
    int err_total = 0, n_tests = 0;
    localparam logic [3:0] CODES [8] = '{4'h0, 4'h4, 4'h9, 4'ha,
        4'hd, 4'he, 4'h5, 4'hf};

    // Device under test
    spc_top dut_u (.*);

    // Clock
    always #25 clk = ~clk;

    //------------------------------------------------------------------
    // Shared tasks
    //------------------------------------------------------------------
    task chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [2:0] a,
        input logic [31:0] wd, input logic [3:0] be);
        int n = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        chk(n, 2);
        rd = avs_readdata;
        rs = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task rdchk(input logic [2:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(rd, exp);
        chk(rs, (a > 3) ? RESP_DECODE_ERR : RESP_OKAY);
    endtask

    task settle();
        repeat (2) @(posedge clk);
    endtask

    function logic ex(input logic [3:0] c);
        case (c)
            4'h0: ex = pll_lock;
            4'h4: ex = xtal_loss_flag;
            4'h9: ex = device_int_sts & device_int_en;
            4'ha: ex = startup_done;
            4'he: ex = 1'b1;
            default: ex = 1'b0;
        endcase
    endfunction

    //------------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------------
    task t_boot();
        chk({dout_pullup_en, dout_pulldown_en}, 2'b10);
        rdchk(REG_DOUT_CFG, {16'h0, DOUT_CFG_RST});
        status_pin_in <= 1'b0;
        die_bond_option <= 1'b0;
        bus(1'b1, REG_BOOT_STS, 32'hffff_ffff, 4'hf);
        rdchk(REG_BOOT_STS, 32'h0000_00ad);
        rdchk(REG_SCRATCH, 32'h0);
        $display("test boot done");
    endtask

    task t_src();
        logic e;
        for (int p = 0; p < 2; p++)
            for (int k = 0; k < 3; k++)
                for (int i = 0; i < 8; i++)
                begin
                    pll_lock <= k[0];
                    xtal_loss_flag <= !k[0];
                    device_int_sts <= k[0] | k[1];
                    device_int_en <= !k[1];
                    startup_done <= !k[0];
                    bus(1'b1, REG_DOUT_CFG,
                        {23'h0, p[0], 4'h0, CODES[i]}, 4'hf);
                    settle();
                    e = ex(CODES[i]) ^ p[0];
                    chk({dout_pin_o, dout_pin_oe}, {e, 1'b1});
                end
        $display("test sources done");
    endtask

    task t_od();
        for (int p = 0; p < 2; p++)
            for (int v = 0; v < 2; v++)
            begin
                bus(1'b1, REG_DOUT_CFG, {19'h0, 4'h8, p[0], 4'h0,
                    (v[0] ? 4'he : 4'hd)}, 4'hf);
                settle();
                chk({dout_pin_o, dout_pin_oe}, {1'b0, v[0] ~^ p[0]});
            end
        $display("test open-drain done");
    endtask

    task t_pad();
        bus(1'b1, REG_DOUT_CFG, 32'hffff_ffff, 4'h3);
        rdchk(REG_DOUT_CFG, 32'h0000_1f0f);
        settle();
        chk(dout_pin_oe, 1'b0);
        chk({dout_pullup_en, dout_pulldown_en}, 2'b11);
        bus(1'b1, REG_DOUT_CFG, 32'h0000_040e, 4'hf);
        settle();
        chk({dout_pullup_en, dout_pulldown_en}, 2'b01);
        for (int d = 0; d < 3; d++)
        begin
            spi_4wire_mode <= 1'b1;
            spi_read_data <= d[0];
            spi_read_oe <= !d[1];
            settle();
            chk({dout_pin_o, dout_pin_oe}, {d[0], !d[1]});
        end
        bus(1'b1, REG_DOUT_CFG, 32'h0000_080e, 4'hf);
        spi_read_oe <= 1'b1;
        settle();
        chk(dout_pin_oe, 1'b0);
        spi_4wire_mode <= 1'b0;
        $display("test pad done");
    endtask

    task t_live();
        logic [4:0] sel [5];
        logic [9:0] exp;
        sel = '{5'h00, 5'h00, 5'h04, 5'h1e, 5'h05};
        exp = 10'b01_01_10_00_11;
        pll_lock <= 1'b1;
        xtal_loss_flag <= 1'b1;
        for (int j = 0; j < 5; j++)
        begin
            status_pin_sel <= sel[j];
            status_pin_pol <= (j == 1 || j == 4);
            output_gate_pin <= (j != 2);
            output_gate_fn_sel <= (j == 1);
            settle();
            rdchk(REG_LIVE_STS, {30'h0, exp[2*j +: 2]});
        end
        $display("test live done");
    endtask

    task t_scr();
        bus(1'b1, REG_SCRATCH, 32'hdead_beef, 4'hf);
        bus(1'b1, REG_SCRATCH, 32'h0000_5500, 4'h2);
        rdchk(REG_SCRATCH, 32'hdead_55ef);
        otp_scratch_word <= 32'h1234_5678;
        otp_load <= 1'b1;
        @(posedge clk);
        otp_load <= 1'b0;
        settle();
        chk(scratch_word, 32'h1234_5678);
        bus(1'b1, 3'h5, 32'hffff_ffff, 4'hf);
        rdchk(3'h5, 32'h0);
        rdchk(REG_SCRATCH, 32'h1234_5678);
        $display("test scratch done");
    endtask

    //------------------------------------------------------------------
    // Run control
    //------------------------------------------------------------------
    task wrap_up();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_boot();
        t_src();
        t_od();
        t_pad();
        t_live();
        t_scr();
        wrap_up();
    end

    // Watchdog
    initial
    begin
        #(20000 * 50);
        err_total++;
        wrap_up();
    end
endmodule // spc_top_tb_top
